// ### dslc_config_reset.v
`include "dslc_regs.vh"

module dslc_config_reset (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Remote write and read commands from the first control port
  input  wire        poke_valid,
  input  wire        poke_write,
  input  wire [7:0]  poke_addr,
  input  wire [7:0]  poke_wdata,
  output wire        poke_ack,
  output wire [7:0]  poke_rdata,
  output wire        poke_err,
  // Reset command messages
  input  wire        reset_cmd_valid,
  input  wire [1:0]  reset_cmd_level,
  output wire        reset_ack,
  output wire        reset_ack_ok,
  // Switch-wide controls
  output wire [5:0]  root_clock_factor,
  output wire        proc_active,
  output wire        drop_packets,
  // Per-link configuration towards the link engines
  output wire [7:0]  tx_divider,
  output wire [3:0]  use_divided_rate,
  output wire [3:0]  contain_faults,
  output wire [39:0] link_rate_half_mbps,
  output wire [3:0]  link_halt,
  // Per-link actions towards the link engines
  output wire [3:0]  engine_clear,
  output wire [3:0]  engine_launch,
  output wire [3:0]  drive_pins_low,
  output wire [3:0]  inject_bad_check_bit,
  // Per-link events and levels from the link engines
  input  wire [3:0]  eng_parity_err,
  input  wire [3:0]  eng_disc_err,
  input  wire [3:0]  eng_token_rx,
  input  wire [3:0]  eng_running,
  input  wire [3:0]  eng_pins_low
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam [2:0] KIND_NONE   = 3'b000;
  localparam [2:0] KIND_MULT   = 3'b001;
  localparam [2:0] KIND_SWCTL  = 3'b010;
  localparam [2:0] KIND_MODE   = 3'b011;
  localparam [2:0] KIND_CMD    = 3'b100;
  localparam [2:0] KIND_STATUS = 3'b101;

  function [2:0] dslc_decode;
    input [7:0] addr;
    begin
      if (addr == `DSLC_ADDR_MULT) begin
        dslc_decode = KIND_MULT;
      end else if (addr == `DSLC_ADDR_SWCTL) begin
        dslc_decode = KIND_SWCTL;
      end else if (addr[7:4] == `DSLC_LINK_PAGE) begin
        case (addr[1:0])
          `DSLC_OFS_MODE:   dslc_decode = KIND_MODE;
          `DSLC_OFS_CMD:    dslc_decode = KIND_CMD;
          `DSLC_OFS_STATUS: dslc_decode = KIND_STATUS;
          default:          dslc_decode = KIND_NONE;
        endcase
      end else begin
        dslc_decode = KIND_NONE;
      end
    end
  endfunction

  wire [2:0] poke_kind;
  wire [1:0] poke_link;
  wire       poke_wr;
  wire       lvl1;
  wire       lvl2;
  wire       link_wait;

  assign poke_kind = dslc_decode(poke_addr);
  assign poke_link = poke_addr[3:2];
  assign poke_wr   = poke_valid & poke_write;
  assign lvl1      = reset_cmd_valid & (reset_cmd_level == `DSLC_RESET_LVL1);
  assign lvl2      = reset_cmd_valid & (reset_cmd_level == `DSLC_RESET_LVL2);
  assign link_wait = lvl1 | lvl2;

  ////////////////////////////////////////////////////////////////////////
  // Switch-wide registers and reset levels

  reg [5:0] factor_reg;
  reg       proc_reg;
  reg       drop_reg;
  reg       rst_ack_reg;
  reg       rst_ok_reg;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      factor_reg  <= `DSLC_MULT_RESET;
      proc_reg    <= `DSLC_SWCTL_RESET;
      drop_reg    <= 1'b0;
      rst_ack_reg <= 1'b0;
      rst_ok_reg  <= 1'b0;
    end else begin
      drop_reg    <= link_wait;
      rst_ack_reg <= reset_cmd_valid;
      rst_ok_reg  <= link_wait;
      if (lvl1) begin
        factor_reg <= `DSLC_MULT_RESET;
        proc_reg   <= `DSLC_SWCTL_RESET;
      end else if (lvl2) begin
        proc_reg <= 1'b0;
      end else if (poke_wr && poke_kind == KIND_MULT) begin
        factor_reg <= poke_wdata[`DSLC_MULT_MSB:0];
      end else if (poke_wr && poke_kind == KIND_SWCTL) begin
        proc_reg <= poke_wdata[`DSLC_SWCTL_PROC_EN];
      end
    end
  end

  assign root_clock_factor = factor_reg;
  assign proc_active       = proc_reg;
  assign drop_packets      = drop_reg;
  assign reset_ack         = rst_ack_reg;
  assign reset_ack_ok      = rst_ok_reg;

  // Twenty times the factor gives the undivided root rate in half-Mbit/s units
  wire [10:0] root_half;
  assign root_half = {1'b0, factor_reg, 4'b0000} + {3'b000, factor_reg, 2'b00};

  ////////////////////////////////////////////////////////////////////////
  // Per-link registers

  wire [15:0] mode_all;
  wire [23:0] status_all;

  genvar i;
  generate
    for (i = 0; i < `DSLC_NUM_LINKS; i = i + 1) begin : g_link
      wire       sel;
      wire       mode_wr;
      wire       cmd_wr;
      wire [5:0]  st;
      wire [10:0] rate_div;
      reg  [3:0] mode_reg;
      reg        drive_reg;
      reg        inject_reg;
      reg        hist_reg;
      reg        clear_reg;
      reg        launch_reg;
      reg        halt_reg;
      reg  [9:0] rate_reg;

      assign sel     = poke_wr & (poke_link == i);
      assign mode_wr = sel & (poke_kind == KIND_MODE);
      assign cmd_wr  = sel & (poke_kind == KIND_CMD);
      assign rate_div = root_half >> mode_reg[`DSLC_MODE_DIV_MSB:`DSLC_MODE_DIV_LSB];

      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mode_reg   <= `DSLC_MODE_RESET;
          drive_reg  <= 1'b0;
          inject_reg <= 1'b0;
          hist_reg   <= 1'b0;
          clear_reg  <= 1'b0;
          launch_reg <= 1'b0;
          halt_reg   <= 1'b0;
          rate_reg   <= `DSLC_BASE_RATE_HALF;
        end else begin
          clear_reg  <= (cmd_wr & poke_wdata[`DSLC_CMD_CLEAR]) | link_wait;
          launch_reg <= cmd_wr & poke_wdata[`DSLC_CMD_LAUNCH] & ~hist_reg & ~link_wait;
          if (lvl1) begin
            mode_reg   <= `DSLC_MODE_RESET;
            drive_reg  <= 1'b0;
            inject_reg <= 1'b0;
            hist_reg   <= 1'b0;
          end else if (lvl2) begin
            hist_reg <= 1'b0;
          end else begin
            if (mode_wr) begin
              mode_reg <= poke_wdata[3:0];
            end
            if (cmd_wr) begin
              hist_reg   <= poke_wdata[`DSLC_CMD_LAUNCH];
              drive_reg  <= poke_wdata[`DSLC_CMD_PINS_LOW];
              inject_reg <= poke_wdata[`DSLC_CMD_BAD_PARITY];
            end
          end
          // Divider applies only when the divided rate is chosen
          if (mode_reg[`DSLC_MODE_USE_DIV]) begin
            // Large factors overflow the rate field: saturate rather than wrap
            rate_reg <= rate_div[10] ? 10'h3ff : rate_div[9:0];
          end else begin
            rate_reg <= `DSLC_BASE_RATE_HALF;
          end
          // Without containment a fault stops the link until a clear
          halt_reg <= st[`DSLC_ST_ANY_FAULT] & ~mode_reg[`DSLC_MODE_CONTAIN] & ~clear_reg;
        end
      end

      dslc_link_flags u_flags (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .clear         (clear_reg),
        .parity_err_in (eng_parity_err[i]),
        .disc_err_in   (eng_disc_err[i]),
        .token_rx_in   (eng_token_rx[i]),
        .running_in    (eng_running[i]),
        .pins_low_in   (eng_pins_low[i]),
        .pins_low_req  (drive_reg),
        .status        (st)
      );

      assign mode_all[i*4 +: 4]              = mode_reg;
      assign status_all[i*6 +: 6]            = st;
      assign tx_divider[i*2 +: 2]            = mode_reg[`DSLC_MODE_DIV_MSB:`DSLC_MODE_DIV_LSB];
      assign use_divided_rate[i]             = mode_reg[`DSLC_MODE_USE_DIV];
      assign contain_faults[i]               = mode_reg[`DSLC_MODE_CONTAIN];
      assign link_rate_half_mbps[i*10 +: 10] = rate_reg;
      assign link_halt[i]                    = halt_reg;
      assign engine_clear[i]                 = clear_reg;
      assign engine_launch[i]                = launch_reg;
      assign drive_pins_low[i]               = drive_reg;
      assign inject_bad_check_bit[i]         = inject_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read answer

  reg [7:0] read_data;
  reg       bad_access;

  // Command words read as zero and flag an error: they are write-only
  always @* begin
    read_data  = 8'h00;
    bad_access = 1'b0;
    case (poke_kind)
      KIND_MULT:   read_data = {2'b00, factor_reg};
      KIND_SWCTL:  read_data = {7'b000_0000, proc_reg};
      KIND_MODE:   read_data = {4'h0, mode_all[poke_link*4 +: 4]};
      KIND_STATUS: begin
        read_data  = {2'b00, status_all[poke_link*6 +: 6]};
        bad_access = poke_write;
      end
      KIND_CMD:    bad_access = ~poke_write;
      default:     bad_access = 1'b1;
    endcase
  end

  reg       ack_reg;
  reg [7:0] rdata_reg;
  reg       err_reg;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
      err_reg   <= 1'b0;
    end else begin
      ack_reg   <= poke_valid;
      rdata_reg <= (poke_valid & ~poke_write) ? read_data : 8'h00;
      err_reg   <= poke_valid & bad_access;
    end
  end

  assign poke_ack   = ack_reg;
  assign poke_rdata = rdata_reg;
  assign poke_err   = err_reg;

endmodule // dslc_config_reset

// ### dslc_link_flags.v
`include "dslc_regs.vh"

module dslc_link_flags (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Engine clear pulse from the command register or a level 1 or 2 reset command
  input  wire       clear,
  // Events and levels from the link engine
  input  wire       parity_err_in,
  input  wire       disc_err_in,
  input  wire       token_rx_in,
  input  wire       running_in,
  input  wire       pins_low_in,
  // Forcing-low request currently held
  input  wire       pins_low_req,
  // Status word
  output wire [5:0] status
);

  reg parity_reg;
  reg disc_reg;
  reg fault_reg;
  reg rx_seen_reg;
  reg running_reg;
  reg pins_done_reg;

  // A fault arriving with the clear pulse is kept: set beats clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      parity_reg    <= 1'b0;
      disc_reg      <= 1'b0;
      fault_reg     <= 1'b0;
      rx_seen_reg   <= 1'b0;
      running_reg   <= 1'b0;
      pins_done_reg <= 1'b0;
    end else begin
      parity_reg    <= parity_err_in | (parity_reg & ~clear);
      disc_reg      <= disc_err_in | (disc_reg & ~clear);
      fault_reg     <= parity_err_in | disc_err_in | (fault_reg & ~clear);
      rx_seen_reg   <= token_rx_in | (rx_seen_reg & ~clear);
      running_reg   <= running_in & ~parity_err_in & ~disc_err_in
                       & ~(fault_reg & ~clear);
      pins_done_reg <= pins_low_req & pins_low_in;
    end
  end

  assign status = {rx_seen_reg, disc_reg, parity_reg, pins_done_reg, running_reg, fault_reg};

endmodule // dslc_link_flags

// ### dslc_props_properties.sv
module dslc_props (
  // Clock and reset
  input logic        clk_sys,
  input logic        rst_n,
  // Remote commands
  input logic        poke_valid,
  input logic        poke_write,
  input logic        poke_ack,
  input logic        reset_cmd_valid,
  input logic [1:0]  reset_cmd_level,
  input logic        reset_ack,
  input logic        reset_ack_ok,
  // Configuration and actions
  input logic [5:0]  root_clock_factor,
  input logic        proc_active,
  input logic        drop_packets,
  input logic [7:0]  tx_divider,
  input logic [3:0]  use_divided_rate,
  input logic [3:0]  contain_faults,
  input logic [39:0] link_rate_half_mbps,
  input logic [3:0]  engine_clear,
  input logic [3:0]  engine_launch
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [10:0] want_rate;
  assign want_rate = ({5'h00, root_clock_factor} * 11'h014) >> tx_divider[1:0];
  ////////////////////////////////////////////////////////////////////////
  a_poke_answer: assert property (poke_valid |=> poke_ack) else $error("poke not answered");
  a_reset_status: assert property (reset_cmd_valid |=> reset_ack
    && (reset_ack_ok == ($past(reset_cmd_level) == 2'h1 || $past(reset_cmd_level) == 2'h2)))
    else $error("reset status wrong");
  a_level_one: assert property (reset_cmd_valid && reset_cmd_level == 2'h1 |=> root_clock_factor == 6'h08
    && use_divided_rate == 4'h0 && contain_faults == 4'h0 && !proc_active) else $error("level one left state");
  a_level_two: assert property (reset_cmd_valid && reset_cmd_level == 2'h2 |=> $stable(root_clock_factor)
    && $stable(contain_faults) && !proc_active) else $error("level two state wrong");
  // A poke in the same cycle may legally change registers, so it is excluded
  a_level_three: assert property (reset_cmd_valid && reset_cmd_level == 2'h3 && !poke_valid |=>
    $stable(root_clock_factor) && $stable(proc_active) && engine_clear == 4'h0 && !drop_packets)
    else $error("level three had effect");
  a_reset_drops: assert property (reset_cmd_valid && (reset_cmd_level[1] != reset_cmd_level[0]) |=>
    engine_clear == 4'hf && drop_packets) else $error("reset kept packets");
  a_base_rate: assert property (!use_divided_rate[0] && $past(!use_divided_rate[0]) |->
    link_rate_half_mbps[9:0] == 10'h014) else $error("base rate wrong");
  a_divided_rate: assert property (use_divided_rate[0] && $past(use_divided_rate[0]) && $stable(tx_divider[1:0])
    && $stable(root_clock_factor) |-> link_rate_half_mbps[9:0] == (want_rate[10] ? 10'h3ff : want_rate[9:0]))
    else $error("divided rate wrong");
  a_launch_cause: assert property (engine_launch != 4'h0 |-> $past(poke_valid && poke_write))
    else $error("launch without write");
  a_clear_cause: assert property (engine_clear != 4'h0 |-> $past(poke_valid && poke_write || reset_cmd_valid))
    else $error("clear without cause");
endmodule // dslc_props

bind dslc_config_reset dslc_props i_props (.*);

// ### dslc_regs.vh
`ifndef DSLC_REGS_VH
`define DSLC_REGS_VH

////////////////////////////////////////////////////////////////////////
// Remote write address map
`define DSLC_ADDR_W           8
`define DSLC_DATA_W           8
`define DSLC_ADDR_MULT        8'h00
`define DSLC_ADDR_SWCTL       8'h01
`define DSLC_LINK_PAGE        4'h1
`define DSLC_OFS_MODE         2'h0
`define DSLC_OFS_CMD          2'h1
`define DSLC_OFS_STATUS       2'h2
`define DSLC_NUM_LINKS        4

////////////////////////////////////////////////////////////////////////
// Field positions
`define DSLC_MULT_MSB         5
`define DSLC_MODE_DIV_MSB     1
`define DSLC_MODE_DIV_LSB     0
`define DSLC_MODE_USE_DIV     2
`define DSLC_MODE_CONTAIN     3
`define DSLC_CMD_CLEAR        0
`define DSLC_CMD_LAUNCH       1
`define DSLC_CMD_PINS_LOW     2
`define DSLC_CMD_BAD_PARITY   3
`define DSLC_ST_ANY_FAULT     0
`define DSLC_ST_RUNNING       1
`define DSLC_ST_PINS_LOW_DONE 2
`define DSLC_ST_PARITY        3
`define DSLC_ST_DISCONNECT    4
`define DSLC_ST_RX_SEEN       5
`define DSLC_SWCTL_PROC_EN    0

////////////////////////////////////////////////////////////////////////
// Reset values
`define DSLC_MULT_RESET       6'h08
`define DSLC_MODE_RESET       4'h0
`define DSLC_SWCTL_RESET      1'b0

////////////////////////////////////////////////////////////////////////
// Reset command levels
`define DSLC_RESET_LVL1       2'h1
`define DSLC_RESET_LVL2       2'h2
`define DSLC_RESET_LVL3       2'h3

////////////////////////////////////////////////////////////////////////
// Clock and rates; DSLC_BASE_RATE_HALF is in units of 0.5 Mbit/s
`define DSLC_INPUT_CLK_MHZ    5
`define DSLC_BASE_RATE_MBPS   10
`define DSLC_BASE_RATE_HALF   10'h014

`endif

// ### dslc_remote_host.sv
module dslc_remote_host (
  // Clock
  input  logic       clk_sys,
  // Poke requests
  output logic       poke_valid = 1'b0,
  output logic       poke_write = 1'b0,
  output logic [7:0] poke_addr = 8'h00,
  output logic [7:0] poke_wdata = 8'h00,
  input  logic       poke_ack,
  input  logic [7:0] poke_rdata,
  input  logic       poke_err,
  // Reset messages
  output logic       reset_cmd_valid = 1'b0,
  output logic [1:0] reset_cmd_level = 2'h0,
  input  logic       reset_ack,
  input  logic       reset_ack_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released address, data and level lines show the inverse so a stale value never looks valid
  task automatic poke(input logic w, input logic [7:0] a, d, output logic ack, output logic [7:0] rd, output logic err);
    @(posedge clk_sys);
    #1;
    poke_valid = 1'b1;
    poke_write = w;
    poke_addr = a;
    poke_wdata = d;
    @(posedge clk_sys);
    #1;
    poke_valid = 1'b0;
    poke_addr = ~a;
    poke_wdata = ~d;
    ack = poke_ack;
    rd = poke_rdata;
    err = poke_err;
  endtask
  task automatic rcmd(input logic [1:0] lv, output logic ack, ok);
    @(posedge clk_sys);
    #1;
    reset_cmd_valid = 1'b1;
    reset_cmd_level = lv;
    @(posedge clk_sys);
    #1;
    reset_cmd_valid = 1'b0;
    reset_cmd_level = ~lv;
    ack = reset_ack;
    ok = reset_ack_ok;
  endtask
endmodule // dslc_remote_host

// ### tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  eng_parity_err = 4'h0, eng_disc_err = 4'h0, eng_token_rx = 4'h0, eng_running = 4'h0;
  logic [3:0]  eng_pins_low = 4'h0;
  wire         poke_valid, poke_write, poke_ack, poke_err, reset_cmd_valid, reset_ack, reset_ack_ok;
  wire         proc_active, drop_packets;
  wire [7:0]   poke_addr, poke_wdata, poke_rdata, tx_divider;
  wire [1:0]   reset_cmd_level;
  wire [5:0]   root_clock_factor;
  wire [3:0]   use_divided_rate, contain_faults, link_halt, engine_clear, engine_launch;
  wire [3:0]   drive_pins_low, inject_bad_check_bit;
  wire [39:0]  link_rate_half_mbps;
  int          n_errors = 0;
  int          total_checks = 0;
  logic        ack, err;
  logic [7:0]  rdv;

  dslc_config_reset i_dut (.*);
  dslc_remote_host i_host (.*);
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [39:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_host.poke(1'b1, a, d, ack, rdv, err);
    chk("write answer", {ack, err}, 2'b10);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    i_host.poke(1'b0, a, 8'h00, ack, rdv, err);
    chk("read answer", {ack, err, rdv}, {2'b10, exp});
  endtask
  task automatic bad(input logic w, input logic [7:0] a);
    i_host.poke(w, a, 8'h0f, ack, rdv, err);
    chk("refused access", {ack, err, rdv}, {2'b11, 8'h00});
  endtask
  task automatic evt(input logic [3:0] p, dc, tk);
    eng_parity_err = p;
    eng_disc_err = dc;
    eng_token_rx = tk;
    @(posedge clk_sys);
    #1;
    {eng_parity_err, eng_disc_err, eng_token_rx} = 12'h000;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rd(8'h00, 8'h08);
    for (int n = 0; n < 4; n++) begin
      rd(8'(16 + 4 * n), 8'h00);
      rd(8'(18 + 4 * n), 8'h00);
    end
    bad(1'b0, 8'h11);
    bad(1'b1, 8'h12);
    bad(1'b1, 8'h13);
  endtask
  task automatic t_speeds;
    wr(8'h00, 8'h0a);
    for (int d = 0; d < 4; d++) begin
      wr(8'h14, 8'(4 + d));
      chk("divider", {tx_divider[3:2], use_divided_rate[1]}, 40'(d * 2 + 1));
      @(posedge clk_sys);
      #1;
      chk("divided rate", link_rate_half_mbps[19:10], 40'(200 >> d));
    end
    wr(8'h14, 8'h08);
    chk("containment", {contain_faults[1], use_divided_rate[1]}, 2'b10);
    @(posedge clk_sys);
    #1;
    chk("base rate", link_rate_half_mbps[19:10], 10'h014);
    rd(8'h14, 8'h08);
  endtask
  task automatic t_commands;
    wr(8'h11, 8'h02);
    chk("launch", engine_launch, 4'h1);
    wr(8'h10, 8'h07);
    rd(8'h10, 8'h07);
    wr(8'h11, 8'h02);
    chk("no relaunch", engine_launch, 4'h0);
    wr(8'h11, 8'h0d);
    chk("actions", {engine_clear, engine_launch, drive_pins_low, inject_bad_check_bit}, 16'h1011);
    wr(8'h11, 8'h02);
    chk("launch again", engine_launch, 4'h1);
  endtask
  task automatic t_status;
    eng_running[3] = 1'b1;
    rd(8'h1e, 8'h02);
    wr(8'h1d, 8'h04);
    eng_pins_low[3] = 1'b1;
    rd(8'h1e, 8'h06);
    evt(4'h8, 4'h0, 4'h0);
    rd(8'h1e, 8'h0d);
    chk("halt", link_halt[3], 1'b1);
    evt(4'h0, 4'h8, 4'h8);
    rd(8'h1e, 8'h3d);
    eng_running[3] = 1'b0;
    eng_pins_low[3] = 1'b0;
    wr(8'h1d, 8'h01);
    rd(8'h1e, 8'h00);
  endtask
  task automatic t_resets;
    wr(8'h00, 8'h0c);
    wr(8'h10, 8'h0f);
    wr(8'h01, 8'h01);
    i_host.rcmd(2'h2, ack, err);
    chk("level two", {ack, err, proc_active, engine_clear, drop_packets}, 8'hdf);
    rd(8'h00, 8'h0c);
    rd(8'h10, 8'h0f);
    i_host.rcmd(2'h3, ack, err);
    chk("level three", {ack, err, engine_clear, drop_packets}, 7'h40);
    wr(8'h01, 8'h01);
    i_host.rcmd(2'h1, ack, err);
    chk("level one", {ack, err, proc_active, engine_clear, drop_packets}, 8'hdf);
    rd(8'h00, 8'h08);
    rd(8'h10, 8'h00);
    wr(8'h00, 8'h0c);
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rd(8'h00, 8'h08);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_defaults;
    t_speeds;
    t_commands;
    t_status;
    t_resets;
    summarize;
  end
  // Whole run is about 120 cycles; this bound leaves wide margin
  initial begin
    #100_000;
    n_errors++;
    summarize;
  end
endmodule // tb
